/* File: src/instruction_timing_decode.sv */
// Instruction decode, cycle timing and read-modify-write strobes
// Operation
// - One 14-bit word carries opcode and all operands, no extension words
// - Each opcode falls in byte, bit or literal-and-control class
// - Instructions outside multi-cycle groups finish in one cycle
// - Both subroutine calls take two instruction cycles
// - Return, literal return and interrupt return take two cycles
// - Jumps, branches and skip instructions take two cycles
// - Indirect access through pointer into program memory adds one cycle
// - One instruction cycle is four oscillator clocks
// - File register writes run as read, modify, then store
// - The addressed file register is read even for write-only ops
// - Destination bit clear routes to accumulator, set to file
// - File address field spans 128 locations 0x00 to 0x7F
// - Bit field selects one bit of an eight-bit register
// - Pointer field selects one of two pointers and access registers
// - Two-bit mode picks increment or decrement, before or after
// - Don't-care word bits never change the decoded behaviour
// - Add with carry decodes as byte op, updates carry, digit, zero
module instruction_timing_decode
   import instruction_timing_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [INSTR_W-1:0]     instrWord,
   input  wire logic [1:0]             ptrInProgMem,
   output logic [1:0]                  qPhase,
   output logic                        fetchAccept,
   output instr_class_t                instrClass,
   output logic [FILE_ADDR_W-1:0]      fileAddr,
   output logic                        destToFile,
   output logic [BIT_ADDR_W-1:0]       bitAddr,
   output logic [LITERAL_W-1:0]        literal,
   output logic                        ptrSel,
   output logic [1:0]                  ptrUpdateMode,
   output logic                        ptrDecrement,
   output logic                        ptrBeforeAccess,
   output logic                        indirectAccess,
   output logic                        callOp,
   output logic                        returnOp,
   output logic                        flowChange,
   output logic [FLAG_W-1:0]           flagMask,
   output logic [1:0]                  cycleCount,
   output logic                        indirectStall,
   output logic                        flushActive,
   output logic                        fileReadStrobe,
   output logic                        fileWriteStrobe,
   output logic                        accWriteStrobe
);

   instr_class_t     cls;
   logic             rdF;
   logic             wrF;
   logic             wrA;
   logic             flow;
   logic             call;
   logic             ret;
   logic             ind;
   logic             ptr;
   logic [1:0]       mode;
   logic [2:0]       flags;
   logic             slowInd;
   logic [3:0]       hi;

   // Decode of the incoming word; only defined fields are looked at
   always_comb begin
      hi    = instrWord[11:8];
      cls   = CLASS_LITCTRL;
      rdF   = 1'b0;
      wrF   = 1'b0;
      wrA   = 1'b0;
      flow  = 1'b0;
      call  = 1'b0;
      ret   = 1'b0;
      ind   = 1'b0;
      ptr   = 1'b0;
      mode  = instrWord[1:0];
      flags = 3'h0;
      case (instrWord[13:12])
         2'h1: begin
            cls = CLASS_BIT;
            rdF = 1'b1;
            if (instrWord[SKIP_POS]) begin
               flow = 1'b1;
            end else begin
               wrF = 1'b1;
            end
         end
         2'h2: begin
            flow = 1'b1;
            call = ~instrWord[SKIP_POS];
         end
         2'h3: begin
            case (hi)
               ADD_WITH_CARRY_OP, SUB_WITH_BORROW_OP,
               ARITH_SHIFT_OP, LOGIC_LEFT_OP, LOGIC_RIGHT_OP: begin
                  cls   = CLASS_BYTE;
                  rdF   = 1'b1;
                  wrF   = instrWord[DEST_POS];
                  wrA   = ~instrWord[DEST_POS];
                  flags = (hi == ADD_WITH_CARRY_OP ||
                           hi == SUB_WITH_BORROW_OP) ?
                          FLAGS_ARITH : FLAGS_SHIFT;
               end
               RETURN_WITH_LITERAL_OP: begin
                  ret = 1'b1;
                  wrA = 1'b1;
               end
               4'h2, 4'h3: flow = 1'b1;
               INDIRECT_OFFSET_OP: begin
                  ind = 1'b1;
                  ptr = instrWord[OFS_PTR_POS];
                  rdF = 1'b1;
                  wrF = instrWord[OFS_DIR_POS];
                  wrA = ~instrWord[OFS_DIR_POS];
                  mode = 2'h0;
               end
               4'hE, 4'hC: begin
                  wrA   = 1'b1;
                  flags = FLAGS_ARITH;
               end
               4'h8, 4'h9, 4'hA: begin
                  wrA   = 1'b1;
                  flags = FLAGS_ZERO;
               end
               4'h0: wrA = 1'b1;
               default: wrA = 1'b0;
            endcase
         end
         default: begin
            if (hi != 4'h0) begin
               cls = CLASS_BYTE;
               rdF = (hi != 4'h1) || instrWord[DEST_POS];
               wrF = instrWord[DEST_POS];
               wrA = ~instrWord[DEST_POS];
               case (hi)
                  4'hB, 4'hF: flow = 1'b1;
                  4'h7, 4'h2: flags = FLAGS_ARITH;
                  4'hD, 4'hC: flags = FLAGS_CARRY;
                  4'hE:       flags = 3'h0;
                  default:    flags = FLAGS_ZERO;
               endcase
            end else if (instrWord[DEST_POS]) begin
               cls = CLASS_BYTE;
               rdF = 1'b1;
               wrF = 1'b1;
            end else if (instrWord[6:4] == INDIRECT_MOVE_GROUP) begin
               ind = 1'b1;
               ptr = instrWord[MOVE_PTR_POS];
               rdF = 1'b1;
               wrF = instrWord[MOVE_DIR_POS];
               wrA = ~instrWord[MOVE_DIR_POS];
               if (!instrWord[MOVE_DIR_POS]) begin
                  flags = FLAGS_ZERO;
               end
            end else begin
               case (instrWord[6:0])
                  RETURN_OP, INTERRUPT_RETURN_OP: ret = 1'b1;
                  CALL_VIA_ACCUMULATOR_OP: begin
                     call = 1'b1;
                     flow = 1'b1;
                  end
                  BRANCH_BY_ACCUMULATOR_OP: flow = 1'b1;
                  default: flow = 1'b0;
               endcase
            end
         end
      endcase
      if (cls != CLASS_LITCTRL && rdF &&
          (instrWord[6:0] == INDIRECT0_ADDR ||
           instrWord[6:0] == INDIRECT1_ADDR)) begin
         ind = 1'b1;
         ptr = instrWord[0];
      end
   end

   assign slowInd = ind & ptrInProgMem[ptr];

   cyc_kind_t   kindReg;
   cyc_kind_t   kindNext;
   logic [1:0]  qReg;
   logic        hasIndReg;
   logic        hasFlushReg;
   logic        rdReg;
   logic        wrFReg;
   logic        wrAReg;
   logic        lastCycle;
   logic        dataCycle;

   always_comb begin
      kindNext  = CYC_EXEC;
      lastCycle = 1'b0;
      case (kindReg)
         CYC_EXEC: begin
            if (hasIndReg) begin
               kindNext = CYC_INDIRECT;
            end else if (hasFlushReg) begin
               kindNext = CYC_FLUSH;
            end else begin
               lastCycle = 1'b1;
            end
         end
         CYC_INDIRECT: begin
            if (hasFlushReg) begin
               kindNext = CYC_FLUSH;
            end else begin
               lastCycle = 1'b1;
            end
         end
         CYC_FLUSH: lastCycle = 1'b1;
         default:   lastCycle = 1'b1;
      endcase
   end

   assign fetchAccept = (qReg == Q_LAST) && lastCycle;

   // Oscillator phase within the instruction cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qReg <= Q_FIRST;
      end else begin
         qReg <= 2'(qReg + 2'h1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kindReg <= CYC_EXEC;
      end else if (qReg == Q_LAST) begin
         kindReg <= kindNext;
      end
   end

   // Whole word taken at once; core starts on a no-op after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instrClass    <= CLASS_BYTE;
         fileAddr      <= NOP_WORD[6:0];
         destToFile    <= 1'b0;
         bitAddr       <= 3'h0;
         literal       <= 11'h000;
         ptrSel        <= 1'b0;
         ptrUpdateMode <= 2'h0;
         indirectAccess <= 1'b0;
         callOp        <= 1'b0;
         returnOp      <= 1'b0;
         flowChange    <= 1'b0;
         flagMask      <= 3'h0;
         cycleCount    <= ONE_CYCLE;
         hasIndReg     <= 1'b0;
         hasFlushReg   <= 1'b0;
         rdReg         <= 1'b0;
         wrFReg        <= 1'b0;
         wrAReg        <= 1'b0;
      end else if (fetchAccept) begin
         instrClass    <= cls;
         fileAddr      <= instrWord[6:0];
         destToFile    <= instrWord[DEST_POS];
         bitAddr       <= instrWord[BIT_ADDR_LSB +: BIT_ADDR_W];
         literal       <= instrWord[LITERAL_W-1:0];
         ptrSel        <= ptr;
         ptrUpdateMode <= mode;
         indirectAccess <= ind;
         callOp        <= call;
         returnOp      <= ret;
         flowChange    <= flow;
         flagMask      <= flags;
         cycleCount    <= 2'(((flow | ret) ? TWO_CYCLES : ONE_CYCLE)
                             + {1'b0, slowInd});
         hasIndReg     <= slowInd;
         hasFlushReg   <= flow | ret;
         rdReg         <= rdF;
         wrFReg        <= wrF;
         wrAReg        <= wrA;
      end
   end

   // Counter modes act only on indirect moves; pre when mode bit 1 clear
   assign ptrDecrement    = ptrUpdateMode[0];
   assign ptrBeforeAccess = ~ptrUpdateMode[1];

   // The extra cycle carries the program memory read, so data moves then
   assign dataCycle = hasIndReg ? (kindReg == CYC_INDIRECT)
                                : (kindReg == CYC_EXEC);

   assign qPhase          = qReg;
   assign indirectStall   = (kindReg == CYC_INDIRECT);
   assign flushActive     = (kindReg == CYC_FLUSH);
   assign fileReadStrobe  = rdReg && dataCycle && qReg == Q_READ;
   assign fileWriteStrobe = wrFReg && dataCycle && qReg == Q_WRITE;
   assign accWriteStrobe  = wrAReg && dataCycle && qReg == Q_WRITE;

   a_phase_wrap: assert property (
      @(posedge clk) disable iff (!rst_n)
      qPhase == Q_LAST |=> qPhase == Q_FIRST)
      else $error("phase did not wrap after four clocks");

   a_accept_space: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept |=> !fetchAccept [*3])
      else $error("instruction taken inside one cycle");

   a_single_cycle: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept ##1 (cycleCount == ONE_CYCLE) |-> ##3 fetchAccept)
      else $error("single-cycle instruction ran long");

   a_call_length: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept ##1 (callOp && !indirectAccess)
      |-> !fetchAccept [*7] ##1 fetchAccept)
      else $error("call did not take two cycles");

   a_return_length: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept ##1 returnOp |-> !fetchAccept [*7] ##1 fetchAccept)
      else $error("return did not take two cycles");

   a_flow_flush: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept ##1 (flowChange && !indirectAccess)
      |-> ##4 (flushActive && !fileWriteStrobe) [*4])
      else $error("flow change did not run a no-op cycle");

   a_indirect_extra: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept && slowInd |=> ##4 indirectStall [*4])
      else $error("missing extra cycle for program memory pointer");

   a_rmw_order: assert property (
      @(posedge clk) disable iff (!rst_n)
      fileWriteStrobe |-> $past(fileReadStrobe, 2))
      else $error("file write without preceding read");

   a_dest_route: assert property (
      @(posedge clk) disable iff (!rst_n)
      (fileWriteStrobe || accWriteStrobe) && instrClass == CLASS_BYTE
      |-> fileWriteStrobe == destToFile)
      else $error("result routed against destination bit");

   a_carry_flags: assert property (
      @(posedge clk) disable iff (!rst_n)
      fetchAccept && instrWord[13:12] == 2'h3 && hi == ADD_WITH_CARRY_OP
      |=> flagMask == FLAGS_ARITH && instrClass == CLASS_BYTE)
      else $error("add with carry decoded wrongly");

endmodule

/* File: src/instruction_timing_pkg.sv */
// Constants and types for the instruction decode and timing block
package instruction_timing_pkg;
   localparam int INSTR_W     = 14;
   localparam int FILE_ADDR_W = 7;
   localparam int BIT_ADDR_W  = 3;
   localparam int LITERAL_W   = 11;
   localparam int FLAG_W      = 3;

   // Instruction cycle of four oscillator clocks
   localparam int         Q_PER_CYCLE = 4;
   localparam logic [1:0] Q_FIRST     = 2'h0;
   localparam logic [1:0] Q_READ      = 2'h1;
   localparam logic [1:0] Q_WRITE     = 2'h3;
   localparam logic [1:0] Q_LAST      = 2'(Q_PER_CYCLE - 1);

   localparam logic [1:0] ONE_CYCLE   = 2'h1;
   localparam logic [1:0] TWO_CYCLES  = 2'h2;

   // Field positions within the instruction word
   localparam int DEST_POS      = 7;
   localparam int BIT_ADDR_LSB  = 7;
   localparam int MOVE_PTR_POS  = 2;
   localparam int MOVE_DIR_POS  = 3;
   localparam int OFS_PTR_POS   = 6;
   localparam int OFS_DIR_POS   = 7;
   localparam int SKIP_POS      = 11;

   // Addresses of the two indirect access registers
   localparam logic [FILE_ADDR_W-1:0] INDIRECT0_ADDR = 7'h00;
   localparam logic [FILE_ADDR_W-1:0] INDIRECT1_ADDR = 7'h01;

   localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

   // Flag mask bit positions
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_DIGIT = 1;
   localparam int FLAG_ZERO  = 2;
   localparam logic [2:0] FLAGS_ARITH = 3'h7;
   localparam logic [2:0] FLAGS_SHIFT = 3'h5;
   localparam logic [2:0] FLAGS_ZERO  = 3'h4;
   localparam logic [2:0] FLAGS_CARRY = 3'h1;

   // Control words of the 00_0000_0 group
   localparam logic [6:0] RETURN_OP               = 7'h08;
   localparam logic [6:0] INTERRUPT_RETURN_OP     = 7'h09;
   localparam logic [6:0] CALL_VIA_ACCUMULATOR_OP = 7'h0A;
   localparam logic [6:0] BRANCH_BY_ACCUMULATOR_OP = 7'h0B;
   localparam logic [2:0] INDIRECT_MOVE_GROUP     = 3'h1;

   // Upper nibble codes of the 11 group
   localparam logic [3:0] ADD_WITH_CARRY_OP   = 4'hD;
   localparam logic [3:0] SUB_WITH_BORROW_OP  = 4'hB;
   localparam logic [3:0] ARITH_SHIFT_OP      = 4'h7;
   localparam logic [3:0] LOGIC_LEFT_OP       = 4'h5;
   localparam logic [3:0] LOGIC_RIGHT_OP      = 4'h6;
   localparam logic [3:0] RETURN_WITH_LITERAL_OP = 4'h4;
   localparam logic [3:0] INDIRECT_OFFSET_OP  = 4'hF;

   typedef enum logic [1:0] {
      CLASS_BYTE,
      CLASS_BIT,
      CLASS_LITCTRL
   } instr_class_t;

   typedef enum {
      CYC_EXEC,
      CYC_INDIRECT,
      CYC_FLUSH
   } cyc_kind_t;
endpackage

/* File: sim/prog_fetch_model.sv */
// Program memory fetch model that offers one word per instruction
module prog_fetch_model
   import instruction_timing_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          fetchAccept,
   output logic [INSTR_W-1:0] instrWord,
   output logic [1:0]         ptrInProgMem
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] rom [0:127];
   logic [6:0]  pc;
   logic        taken;

   initial begin
      pc = 7'h00;
      taken = 1'b0;
      {ptrInProgMem, instrWord} = 16'hFFFF;
   end

   always @(posedge clk) taken <= rst_n && fetchAccept;

   // Junk outside the accept phase catches sampling on the wrong edge
   always @(negedge clk) begin
      if (!rst_n) pc = 7'h00;
      else if (taken) pc = pc + 7'h01;
      if (fetchAccept === 1'b1) {ptrInProgMem, instrWord} = rom[pc];
      else {ptrInProgMem, instrWord} = ~rom[pc];
   end
endmodule

/* File: sim/instruction_timing_decode_tb.sv */
// Self-checking bench for instruction decode and cycle timing
module instruction_timing_decode_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import instruction_timing_pkg::*;

   typedef struct packed {
      instr_class_t cls;
      logic [1:0]   cyc;
      logic         flow, uses, ind, sel, call, ret, fw, aw, rd;
   } exp_t;

   localparam int N = 100;
   localparam logic [15:0] CORNER [16] = '{
      16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h2123, 16'h2ABC,
      16'h3456, 16'h33FF, 16'h3DFF, 16'h7D00, 16'h8B81, 16'h8B80,
      16'h4F80, 16'h9C01, 16'hBF7F, 16'h7F80};

   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic [INSTR_W-1:0]     instrWord;
   logic [1:0]             ptrInProgMem, qPhase, ptrUpdateMode, cycleCount;
   logic                   fetchAccept, destToFile, ptrSel, ptrDecrement;
   logic                   ptrBeforeAccess, indirectAccess, callOp, returnOp;
   logic                   flowChange, indirectStall, flushActive;
   logic                   fileReadStrobe, fileWriteStrobe, accWriteStrobe;
   instr_class_t           instrClass;
   logic [FILE_ADDR_W-1:0] fileAddr;
   logic [BIT_ADDR_W-1:0]  bitAddr;
   logic [LITERAL_W-1:0]   literal;
   logic [FLAG_W-1:0]      flagMask;
   logic [15:0]            prog [0:127];
   logic [31:0]            seed = 32'hB94E2C61;
   int                     errors = 0;
   int                     cmp_count = 0;

   always #12.5 clk = ~clk;

   instruction_timing_decode dut (
      .clk, .rst_n, .instrWord, .ptrInProgMem, .qPhase, .fetchAccept,
      .instrClass, .fileAddr, .destToFile, .bitAddr, .literal, .ptrSel,
      .ptrUpdateMode, .ptrDecrement, .ptrBeforeAccess, .indirectAccess,
      .callOp, .returnOp, .flowChange, .flagMask, .cycleCount,
      .indirectStall, .flushActive, .fileReadStrobe, .fileWriteStrobe,
      .accWriteStrobe);

   prog_fetch_model pm (.clk, .rst_n, .fetchAccept, .instrWord,
      .ptrInProgMem);

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic exp_t expect_of(input logic [15:0] r);
      exp_t        e;
      logic [13:0] w;
      w = r[13:0];
      e = '0;
      e.cls = CLASS_LITCTRL;
      e.sel = w[0];
      if (w[13:12] == 2'h1) begin
         e.cls = CLASS_BIT;
         e.flow = w[11];
         e.fw = !w[11];
      end else if ((w[13:12] == 2'h0 && (w[11:8] != 4'h0 || w[7])) ||
         (w[13:12] == 2'h3 && w[11:8] inside {4'h5, 4'h6, 4'h7, 4'hB,
         4'hD})) begin
         e.cls = CLASS_BYTE;
         e.flow = w[13:12] == 2'h0 && w[11:8] inside {4'hB, 4'hF};
         e.fw = w[7];
         e.aw = !w[7];
      end
      // Clear-accumulator form must not touch a file register
      e.rd = e.cls != CLASS_LITCTRL && !(w[13:8] == 6'h01 && !w[7]);
      if (e.rd) e.uses = w[6:1] == 6'h00;
      e.call = w[13:11] == 3'h4 || w == 14'h000A;
      e.ret = w inside {14'h0008, 14'h0009} || w[13:8] == 6'h34;
      e.flow |= e.call || e.ret || w == 14'h000B || w[13:11] == 3'h5;
      e.flow |= w[13:9] == 5'h19;
      if (w[13:4] == 10'h001) begin
         e.uses = 1'b1;
         e.sel = w[2];
      end
      if (w[13:8] == 6'h3F) begin
         e.uses = 1'b1;
         e.sel = w[6];
      end
      e.ind = e.uses && r[14 + e.sel];
      e.cyc = 2'h1 + e.flow + e.ind;
      return e;
   endfunction

   task automatic check_val(input string nm, input logic [15:0] ex,
                            input logic [15:0] got);
      cmp_count++;
      if (got !== ex) begin
         errors++;
         $display("Error %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   task automatic check_cnt(input string nm, input int ex, input int got);
      cmp_count++;
      if (got != ex) begin
         errors++;
         $display("Error %s expected %0d seen %0d", nm, ex, got);
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      int          i, k, n;
      int          c [5];
      logic [31:0] r;
      logic [6:0]  f;
      logic [13:0] w;
      logic [4:0]  s;
      exp_t        e;
      for (i = 0; i < 128; i++) prog[i] = 16'h0000;
      for (i = 0; i < 16; i++) prog[i] = CORNER[i];
      for (i = 0; i < 16; i++) prog[16 + i] = {i[3], !i[3], 14'(16 + i)};
      // Random byte and bit ops, biased onto the indirect addresses
      for (i = 32; i < N; i++) begin
         r = xs();
         f = r[8] ? {6'h00, r[9]} : r[6:0];
         w = r[10] ? {2'h1, r[15:11], f} :
             {2'h0, 4'(2 + r[19:16] % 14), r[7], f};
         prog[i] = {r[21:20], w};
      end
      // Clear-accumulator words with don't-care bits 6:0 set to 0 through 3
      for (i = 0; i < 4; i++) prog[N - 4 + i] = 16'hC100 + 16'(i);
      for (i = 0; i < 128; i++) pm.rom[i] = prog[i];
      repeat (4) @(negedge clk);
      check_val("qPhase", Q_FIRST, qPhase);
      check_val("cycleCount", ONE_CYCLE, cycleCount);
      check_val("fetchAccept", 1'b0, fetchAccept);
      rst_n = 1'b1;
      for (i = 0; i < N; i++) begin
         for (k = 0; k < 16 && fetchAccept !== 1'b1; k++) @(negedge clk);
         @(negedge clk);
         e = expect_of(prog[i]);
         w = prog[i][13:0];
         check_val("instrClass", e.cls, instrClass);
         check_val("fileAddr", w[6:0], fileAddr);
         check_val("literal", w[10:0], literal);
         check_val("bitAddr", w[9:7], bitAddr);
         check_val("destToFile", w[7], destToFile);
         check_val("cycleCount", e.cyc, cycleCount);
         check_val("flowChange", e.flow && !e.ret, flowChange);
         check_val("callOp", e.call, callOp);
         check_val("returnOp", e.ret, returnOp);
         check_val("indirectAccess", e.uses, indirectAccess);
         if (e.uses) check_val("ptrSel", e.sel, ptrSel);
         if (w[13:4] == 10'h001) begin
            check_val("ptrUpdateMode", w[1:0], ptrUpdateMode);
            check_val("ptrDecrement", w[0], ptrDecrement);
            check_val("ptrBeforeAccess", !w[1], ptrBeforeAccess);
         end
         if (w[13:8] == 6'h3D) begin
            check_val("flagMask", FLAGS_ARITH, flagMask);
         end
         c = '{default: 0};
         n = 0;
         while (n < 16) begin
            n++;
            s = {accWriteStrobe, fileWriteStrobe, fileReadStrobe,
                 indirectStall, flushActive};
            for (k = 0; k < 5; k++) c[k] += int'(s[k] === 1'b1);
            if (fetchAccept === 1'b1) break;
            @(negedge clk);
         end
         check_cnt("clocks", Q_PER_CYCLE * e.cyc, n);
         check_cnt("flush clocks", 4 * e.flow, c[0]);
         check_cnt("stall clocks", 4 * e.ind, c[1]);
         if (e.cls != CLASS_LITCTRL) begin
            check_cnt("file reads", e.rd, c[2]);
            check_cnt("file writes", e.fw, c[3]);
            check_cnt("acc writes", e.aw, c[4]);
         end
      end
      print_verdict();
   end

   // Run needs about 650 clocks; a hang ends here instead
   initial begin
      #60us;
      errors++;
      $display("Error watchdog expected done seen hang");
      print_verdict();
   end
endmodule
